// ### core/pot_pkg.sv
// Purpose: shared constants and types for the wiper potentiometer link
// Assumes: system clock of 25 MHz on both ends
// Notes:   host register map is a local choice; device type code is arbitrary
package pot_pkg;

   // ---------------------------------------------------------------
   // system timing
   // ---------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 40;
   // quarter of a serial clock period made by the host
   localparam int SCL_QTR_NS    = 240;
   localparam int SCL_QTR_CYC   = (SCL_QTR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // ---------------------------------------------------------------
   // address byte and instruction byte layout
   // ---------------------------------------------------------------
   // arbitrary value, not a real part's code
   localparam logic [5:0] DEV_TYPE_CODE   = 6'h2A;
   localparam int         ADDR_TYPE_LSB   = 2;
   localparam int         ADDR_SEL_BIT    = 1;
   localparam int         ADDR_RW_BIT     = 0;
   localparam int         MIDSCALE_BIT    = 6;
   localparam int         SHUTDOWN_BIT    = 5;
   localparam logic [7:0] WIPER_MIDSCALE  = 8'h80;
   // one-hot tap pattern for midscale; the async reset needs a plain constant
   localparam logic [255:0] TAP_RESET     = 256'h1 << WIPER_MIDSCALE;
   localparam logic [1:0] BYTE_INSTR      = 2'h1;
   localparam logic [1:0] BYTE_DATA       = 2'h2;
   localparam logic [2:0] LAST_BIT        = 3'h7;
   localparam logic [3:0] ACK_SLOT        = 4'h8;

   // ---------------------------------------------------------------
   // host register map (byte addresses on the apb port)
   // ---------------------------------------------------------------
   localparam logic [7:0] REG_CTRL        = 8'h00;
   localparam logic [7:0] REG_INSTR       = 8'h04;
   localparam logic [7:0] REG_WDATA       = 8'h08;
   localparam logic [7:0] REG_STATUS      = 8'h0C;
   localparam logic [7:0] REG_RDATA       = 8'h10;
   localparam int         CTRL_GO_BIT     = 0;
   localparam int         CTRL_READ_BIT   = 1;
   localparam int         CTRL_SEL_BIT    = 2;
   localparam logic [7:0] INSTR_RESET     = 8'h00;
   localparam logic [7:0] WDATA_RESET     = 8'h00;

   // ---------------------------------------------------------------
   // state encodings
   // ---------------------------------------------------------------
   typedef enum logic [2:0] {
      D_IDLE = 3'b000,
      D_ADDR = 3'b001,
      D_RECV = 3'b010,
      D_ACK  = 3'b011,
      D_SEND = 3'b100,
      D_MACK = 3'b101,
      D_WAIT = 3'b110
   } dev_state_t;

   typedef enum logic [1:0] {
      H_IDLE  = 2'b00,
      H_START = 2'b01,
      H_BIT   = 2'b10,
      H_STOP  = 2'b11
   } host_state_t;

endpackage

// ### core/pot_link_if.sv
// Purpose: two-wire link between bus master and potentiometer target
// Assumes: both lines open drain with pull-ups; enable high pulls low
// Notes:   resolved line levels are formed here, not in the ends
`timescale 1ns/1ps
interface pot_link_if;
   logic host_scl_out;
   logic host_scl_oe;
   logic host_sda_out;
   logic host_sda_oe;
   logic dev_sda_out;
   logic dev_sda_oe;
   logic scl;
   logic sda;

   // wired-and with pull-up
   assign scl = host_scl_oe ? host_scl_out : 1'b1;
   assign sda = (host_sda_oe && !host_sda_out) || (dev_sda_oe && !dev_sda_out) ? 1'b0 : 1'b1;

   modport device (input scl, input sda, output dev_sda_out, output dev_sda_oe);
   modport host   (input scl, input sda, output host_scl_out, output host_scl_oe,
                   output host_sda_out, output host_sda_oe);
endinterface

// ### core/pot_bus_master.sv
// Purpose: apb-controlled master that writes and reads the wiper register
// Assumes: serial clock derived here from clk, period 4 * SCL_QTR_CYC
// Notes:   one command at a time; go is ignored while busy
`timescale 1ns/1ps
module pot_bus_master
   import pot_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic [7:0]  paddr,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   pot_link_if.host         link
);
   import pot_pkg::*;

   logic        access;
   logic        commit;
   logic        go;
   logic        mapped;
   logic        sel_reg;
   logic        read_reg;
   logic [7:0]  instr_reg;
   logic [7:0]  wdata_reg;
   logic [7:0]  rdata_reg;
   logic        busy_reg;
   logic        nack_reg;
   logic        done_reg;
   logic        sda_m, sda_s;
   host_state_t state_reg;
   logic [1:0]  q_reg;
   logic [7:0]  div_reg;
   logic        tick;
   logic [3:0]  bit_reg;
   logic [1:0]  byte_reg;
   logic [7:0]  shift_reg;
   logic        rx_byte;
   logic        last_byte;

   // ---------------------------------------------------------------
   // apb slave: one wait state, effect at the edge with pready high
   // ---------------------------------------------------------------
   assign access = psel && penable && !pready;
   assign commit = psel && penable && pready;
   assign go     = commit && pwrite && paddr == REG_CTRL && pwdata[CTRL_GO_BIT] && !busy_reg;
   assign mapped = paddr == REG_CTRL || paddr == REG_INSTR || paddr == REG_WDATA ||
                   paddr == REG_STATUS || paddr == REG_RDATA;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0;
      end else begin
         pready  <= access;
         pslverr <= access && !mapped;
         if (access && !pwrite) begin
            unique case (paddr)
               REG_CTRL:   prdata <= {29'h0, sel_reg, read_reg, 1'b0};
               REG_INSTR:  prdata <= {24'h0, instr_reg};
               REG_WDATA:  prdata <= {24'h0, wdata_reg};
               REG_STATUS: prdata <= {29'h0, done_reg, nack_reg, busy_reg};
               REG_RDATA:  prdata <= {24'h0, rdata_reg};
               default:    prdata <= 32'h0;
            endcase
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sel_reg   <= 1'b0;
         read_reg  <= 1'b0;
         instr_reg <= INSTR_RESET;
         wdata_reg <= WDATA_RESET;
      end else if (commit && pwrite && !busy_reg) begin
         if (paddr == REG_CTRL) begin
            sel_reg  <= pwdata[CTRL_SEL_BIT];
            read_reg <= pwdata[CTRL_READ_BIT];
         end
         if (paddr == REG_INSTR) instr_reg <= pwdata[7:0];
         if (paddr == REG_WDATA) wdata_reg <= pwdata[7:0];
      end
   end

   // ---------------------------------------------------------------
   // line sampling
   // ---------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         {sda_m, sda_s} <= 2'h3;
      end else begin
         // target never stretches the clock, so only data is watched
         {sda_m, sda_s} <= {link.sda, sda_m};
      end
   end

   // ---------------------------------------------------------------
   // bit engine
   // ---------------------------------------------------------------
   assign tick      = div_reg == 8'(SCL_QTR_CYC - 1);
   assign rx_byte   = read_reg && byte_reg == BYTE_INSTR;
   assign last_byte = byte_reg == (read_reg ? BYTE_INSTR : BYTE_DATA);

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         div_reg <= 8'h0;
      end else if (state_reg == H_IDLE || tick) begin
         div_reg <= 8'h0;
      end else begin
         div_reg <= div_reg + 8'h1;
      end
   end

   assign link.host_scl_out = 1'b0;
   assign link.host_sda_out = 1'b0;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg        <= H_IDLE;
         q_reg            <= 2'h0;
         bit_reg          <= 4'h0;
         byte_reg         <= 2'h0;
         shift_reg        <= 8'h0;
         busy_reg         <= 1'b0;
         nack_reg         <= 1'b0;
         done_reg         <= 1'b0;
         rdata_reg        <= 8'h0;
         link.host_scl_oe <= 1'b0;
         link.host_sda_oe <= 1'b0;
      end else begin
         unique case (state_reg)
            H_IDLE: if (go) begin
               state_reg <= H_START;
               q_reg     <= 2'h0;
               bit_reg   <= 4'h0;
               byte_reg  <= 2'h0;
               shift_reg <= {DEV_TYPE_CODE, pwdata[CTRL_SEL_BIT], pwdata[CTRL_READ_BIT]};
               busy_reg  <= 1'b1;
               nack_reg  <= 1'b0;
               done_reg  <= 1'b0;
            end
            H_START: if (tick) begin
               q_reg <= q_reg + 2'h1;
               if (q_reg == 2'h0) link.host_sda_oe <= 1'b1;
               else begin
                  link.host_scl_oe <= 1'b1;
                  state_reg        <= H_BIT;
                  q_reg            <= 2'h0;
               end
            end
            H_BIT: if (tick) begin
               q_reg <= q_reg + 2'h1;
               unique case (q_reg)
                  2'h0: link.host_sda_oe <= bit_reg != ACK_SLOT && !rx_byte && !shift_reg[7];
                  2'h1: link.host_scl_oe <= 1'b0;
                  2'h2: if (bit_reg == ACK_SLOT) begin
                     if (!rx_byte) nack_reg <= sda_s;
                  end else begin
                     shift_reg <= {shift_reg[6:0], sda_s};
                  end
                  2'h3: begin
                     link.host_scl_oe <= 1'b1;
                     bit_reg          <= bit_reg + 4'h1;
                     if (bit_reg == ACK_SLOT) begin
                        bit_reg <= 4'h0;
                        if (rx_byte) rdata_reg <= shift_reg;
                        if (nack_reg || last_byte) state_reg <= H_STOP;
                        else begin
                           byte_reg  <= byte_reg + 2'h1;
                           shift_reg <= byte_reg == 2'h0 ? instr_reg : wdata_reg;
                        end
                     end
                  end
               endcase
            end
            H_STOP: if (tick) begin
               q_reg <= q_reg + 2'h1;
               unique case (q_reg)
                  2'h0: link.host_sda_oe <= 1'b1;
                  2'h1: link.host_scl_oe <= 1'b0;
                  2'h2: link.host_sda_oe <= 1'b0;
                  2'h3: begin
                     state_reg <= H_IDLE;
                     busy_reg  <= 1'b0;
                     done_reg  <= 1'b1;
                  end
               endcase
            end
         endcase
      end
   end

endmodule

// ### core/wiper_pot_device.sv
// Purpose: two-wire target logic of a 256-step digital potentiometer
// Assumes: clk fast enough to see every serial clock level (>= 8x)
// Notes:   serial lines and select pin are sampled through two flops
`timescale 1ns/1ps

module wiper_pot_device
   import pot_pkg::*;
(
   input  wire logic         clk,
   input  wire logic         rst_n,
   input  wire logic         addr_select_pin,
   output logic      [7:0]   wiper_position_reg,
   output logic      [255:0] wiper_tap,
   output logic              term_a_open,
   output logic              wiper_to_b,
   pot_link_if.device        link
);
   import pot_pkg::*;

   logic       scl_m, scl_s, scl_q;
   logic       sda_m, sda_s, sda_q;
   logic       sel_m, sel_s;
   logic       start_seen;
   logic       stop_seen;
   logic       scl_rise;
   logic       scl_fall;
   dev_state_t state_reg;
   logic [2:0] bit_reg;
   logic       got_reg;
   logic [1:0] byte_reg;
   logic [7:0] shift_reg;
   logic       read_reg;
   logic       shutdown_flag;
   logic       byte_end;
   logic       addr_hit;
   logic       wr_accept;
   logic       midscale_reset_flag;

   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   function automatic logic [255:0] tap_decode(input logic [7:0] code);
      tap_decode = 256'h1 << code;
   endfunction

   // ---------------------------------------------------------------
   // synchronisers and line events
   // ---------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         {scl_m, scl_s, scl_q} <= 3'h7;
         {sda_m, sda_s, sda_q} <= 3'h7;
      end else begin
         {scl_m, scl_s, scl_q} <= {link.scl, scl_m, scl_s};
         {sda_m, sda_s, sda_q} <= {link.sda, sda_m, sda_s};
      end
   end

   // pin is strapped or slow; synchronised like any other pin
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         {sel_m, sel_s} <= 2'h0;
      end else begin
         {sel_m, sel_s} <= {addr_select_pin, sel_m};
      end
   end

   // any data change while clock high is a start or a stop
   assign start_seen = scl_s && scl_q && sda_q && !sda_s;
   assign stop_seen  = scl_s && scl_q && !sda_q && sda_s;
   assign scl_rise   = scl_s && !scl_q;
   assign scl_fall   = !scl_s && scl_q;

   // ---------------------------------------------------------------
   // byte decode
   // ---------------------------------------------------------------
   assign byte_end  = scl_fall && got_reg;
   assign addr_hit  = shift_reg[7:ADDR_TYPE_LSB] == DEV_TYPE_CODE &&
                      shift_reg[ADDR_SEL_BIT] == sel_s;
   assign wr_accept = state_reg == D_RECV && byte_end;
   // only bits 6 and 5 of the instruction are looked at
   assign midscale_reset_flag = shift_reg[MIDSCALE_BIT];

   // ---------------------------------------------------------------
   // protocol state machine
   // ---------------------------------------------------------------
   assign link.dev_sda_out = 1'b0;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg       <= D_IDLE;
         bit_reg         <= 3'h0;
         got_reg         <= 1'b0;
         byte_reg        <= 2'h0;
         shift_reg       <= 8'h0;
         read_reg        <= 1'b0;
         link.dev_sda_oe <= 1'b0;
      end else if (start_seen) begin
         // a start, repeated or not, always begins a new command
         state_reg       <= D_ADDR;
         bit_reg         <= 3'h0;
         got_reg         <= 1'b0;
         byte_reg        <= 2'h0;
         link.dev_sda_oe <= 1'b0;
      end else if (stop_seen) begin
         state_reg       <= D_IDLE;
         got_reg         <= 1'b0;
         link.dev_sda_oe <= 1'b0;
      end else begin
         unique case (state_reg)
            D_IDLE: begin
               // nothing on the bus counts before a start
               link.dev_sda_oe <= 1'b0;
            end
            D_ADDR, D_RECV: begin
               if (scl_rise) begin
                  shift_reg <= {shift_reg[6:0], sda_s};
                  bit_reg   <= bit_reg + 3'h1;
                  got_reg   <= bit_reg == LAST_BIT;
               end else if (byte_end) begin
                  got_reg <= 1'b0;
                  if (state_reg == D_RECV || addr_hit) begin
                     link.dev_sda_oe <= 1'b1;
                     state_reg       <= D_ACK;
                     if (byte_reg != 2'h3) byte_reg <= byte_reg + 2'h1;
                     if (state_reg == D_ADDR) read_reg <= shift_reg[ADDR_RW_BIT];
                  end else begin
                     state_reg <= D_WAIT;
                  end
               end
            end
            D_ACK: if (scl_fall) begin
               bit_reg <= 3'h0;
               if (read_reg) begin
                  shift_reg       <= wiper_position_reg;
                  link.dev_sda_oe <= !wiper_position_reg[7];
                  state_reg       <= D_SEND;
               end else begin
                  link.dev_sda_oe <= 1'b0;
                  state_reg       <= D_RECV;
               end
            end
            D_SEND: begin
               // data only changes after a falling clock edge
               if (scl_rise) begin
                  bit_reg <= bit_reg + 3'h1;
                  got_reg <= bit_reg == LAST_BIT;
               end else if (scl_fall) begin
                  if (got_reg) begin
                     got_reg         <= 1'b0;
                     link.dev_sda_oe <= 1'b0;
                     state_reg       <= D_MACK;
                  end else begin
                     shift_reg       <= {shift_reg[6:0], 1'b0};
                     link.dev_sda_oe <= !shift_reg[6];
                  end
               end
            end
            D_MACK: begin
               if (scl_rise) begin
                  got_reg <= !sda_s;
               end else if (scl_fall) begin
                  got_reg <= 1'b0;
                  bit_reg <= 3'h0;
                  if (got_reg) begin
                     shift_reg       <= wiper_position_reg;
                     link.dev_sda_oe <= !wiper_position_reg[7];
                     state_reg       <= D_SEND;
                  end else begin
                     state_reg <= D_WAIT;
                  end
               end
            end
            D_WAIT: begin
               link.dev_sda_oe <= 1'b0;
            end
            default: begin
               state_reg       <= D_IDLE;
               link.dev_sda_oe <= 1'b0;
            end
         endcase
      end
   end

   // ---------------------------------------------------------------
   // wiper register and shutdown
   // ---------------------------------------------------------------
   // volatile: power-up and reset both give midscale
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wiper_position_reg <= WIPER_MIDSCALE;
      end else if (wr_accept && byte_reg == BYTE_DATA) begin
         // later bytes are acknowledged but change nothing
         wiper_position_reg <= shift_reg;
      end else if (wr_accept && byte_reg == BYTE_INSTR && midscale_reset_flag) begin
         wiper_position_reg <= WIPER_MIDSCALE;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         shutdown_flag <= 1'b0;
      end else if (wr_accept && byte_reg == BYTE_INSTR) begin
         shutdown_flag <= shift_reg[SHUTDOWN_BIT];
      end
   end

   // ---------------------------------------------------------------
   // tap switch drive
   // ---------------------------------------------------------------
   // shutdown: top open, wiper on the bottom tap; register untouched
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wiper_tap   <= TAP_RESET;
         term_a_open <= 1'b0;
         wiper_to_b  <= 1'b0;
      end else begin
         wiper_tap   <= shutdown_flag ? tap_decode(8'h00)
                                      : tap_decode(wiper_position_reg);
         term_a_open <= shutdown_flag;
         wiper_to_b  <= shutdown_flag;
      end
   end

endmodule

// ### tb/link_chk.sv
// Purpose: protocol checks on the two-wire link between master and wiper target
// Assumes: resolved line levels sampled on the system clock
// Notes:   tracks bit and byte position from the observed serial clock
`timescale 1ns/1ps
module link_chk
   import pot_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic scl,
   input wire logic sda,
   input wire logic dev_sda_oe,
   input wire logic addr_select_pin
);
   // ---------------------------------------------------------------
   // bus tracking
   // ---------------------------------------------------------------
   logic       scl_q, sda_q, busy_reg;
   logic [3:0] bit_reg;
   logic [1:0] byte_reg;
   logic [7:0] sh_reg, addr_reg;
   wire start   = scl && scl_q && sda_q && !sda;
   wire stop    = scl && scl_q && !sda_q && sda;
   wire rise    = scl && !scl_q;
   wire hit_now = sh_reg[7:1] == {DEV_TYPE_CODE, addr_select_pin};
   wire hit     = addr_reg[7:1] == {DEV_TYPE_CODE, addr_select_pin};
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         scl_q    <= 1'b1;
         sda_q    <= 1'b1;
         busy_reg <= 1'b0;
      end else begin
         scl_q    <= scl;
         sda_q    <= sda;
         busy_reg <= start ? 1'b1 : (stop ? 1'b0 : busy_reg);
      end
   end
   // ninth rise closes a byte; address kept for the rest of the frame
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         bit_reg  <= 4'h0;
         byte_reg <= 2'h0;
         sh_reg   <= 8'h00;
         addr_reg <= 8'h00;
      end else if (start) begin
         bit_reg  <= 4'h0;
         byte_reg <= 2'h0;
         sh_reg   <= 8'h00;
         addr_reg <= 8'h00;
      end else if (rise && busy_reg) begin
         bit_reg  <= (bit_reg == 4'h8) ? 4'h0 : bit_reg + 4'h1;
         sh_reg   <= (bit_reg == 4'h8) ? sh_reg : {sh_reg[6:0], sda};
         addr_reg <= (bit_reg == 4'h8 && byte_reg == 2'h0) ? sh_reg : addr_reg;
         byte_reg <= (bit_reg == 4'h8 && byte_reg != 2'h3) ? byte_reg + 2'h1 : byte_reg;
      end
   end
   // ---------------------------------------------------------------
   // properties
   // ---------------------------------------------------------------
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   property p_idle_silent; !busy_reg |-> !dev_sda_oe; endproperty
   property p_start_quiet; start |=> !dev_sda_oe [*8]; endproperty
   property p_dev_stable; scl && scl_q |-> $stable(dev_sda_oe); endproperty
   property p_ack_addr; rise && bit_reg == 4'h8 && byte_reg == 2'h0 && hit_now |-> !sda;
   endproperty
   property p_miss_slot; rise && bit_reg == 4'h8 && byte_reg == 2'h0 && !hit_now |-> sda;
   endproperty
   property p_silent_after; busy_reg && byte_reg != 2'h0 && !hit |-> !dev_sda_oe;
   endproperty
   property p_ack_write;
      rise && bit_reg == 4'h8 && hit && !addr_reg[0] && byte_reg inside {2'h1, 2'h2} |-> !sda;
   endproperty
   property p_read_nack;
      rise && bit_reg == 4'h8 && hit && addr_reg[0] && byte_reg == 2'h1 |-> sda && !dev_sda_oe;
   endproperty
   a_idle_silent: assert property (p_idle_silent) else $error("target drives while idle");
   a_start_quiet: assert property (p_start_quiet) else $error("target drives after start");
   a_dev_stable: assert property (p_dev_stable) else $error("target data moved, clock high");
   a_ack_addr: assert property (p_ack_addr) else $error("address not acknowledged");
   a_miss_slot: assert property (p_miss_slot) else $error("foreign address acknowledged");
   a_silent_after: assert property (p_silent_after) else $error("unselected target drives");
   a_ack_write: assert property (p_ack_write) else $error("write byte not acknowledged");
   a_read_nack: assert property (p_read_nack) else $error("target held data in ack slot");
   c_write: cover property (rise && bit_reg == 4'h8 && hit && !addr_reg[0] && byte_reg == 2'h2);
   c_read: cover property (rise && bit_reg == 4'h8 && hit && addr_reg[0] && byte_reg == 2'h1);
   c_miss: cover property (busy_reg && byte_reg != 2'h0 && !hit);
endmodule

// ### tb/tb.sv
// Purpose: apb-driven master against the wiper target, both ends as built
// Assumes: status polled until done; one command at a time
// Notes:   wiper outputs compared directly after each write command
`timescale 1ns/1ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin fail_count++; \
   $display("mismatch at %0t: got %0h exp %0h", $time, (a), (b)); end end
module tb;
   import pot_pkg::*;
   logic         clk, rst_n, psel, penable, pwrite, pready, pslverr, err, pin, a_open, to_b;
   logic         saw_mid, mid_clr;
   logic [7:0]   paddr, wiper;
   logic [31:0]  pwdata, prdata, q;
   logic [255:0] tap;
   int           fail_count, check_count;
   pot_link_if pot_link_if_i();
   pot_bus_master pot_bus_master_i(.clk, .rst_n, .paddr, .psel, .penable, .pwrite, .pwdata,
      .prdata, .pready, .pslverr, .link(pot_link_if_i));
   wiper_pot_device wiper_pot_device_i(.clk, .rst_n, .addr_select_pin(pin),
      .wiper_position_reg(wiper), .wiper_tap(tap), .term_a_open(a_open), .wiper_to_b(to_b),
      .link(pot_link_if_i));
   link_chk link_chk_i(.clk, .rst_n, .scl(pot_link_if_i.scl), .sda(pot_link_if_i.sda),
      .dev_sda_oe(pot_link_if_i.dev_sda_oe), .addr_select_pin(pin));
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   // midscale is only visible between instruction and data byte
   always @(posedge clk) begin
      if (mid_clr) saw_mid <= 1'b0;
      else if (wiper === WIPER_MIDSCALE) saw_mid <= 1'b1;
   end
   task tally_and_finish();
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1; penable <= 1'b0; paddr <= a; pwrite <= wr; pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      q = prdata; err = pslverr;
      psel <= 1'b0; penable <= 1'b0;
   endtask
   task cmd(input logic rd, input logic sel, input logic [7:0] ins, input logic [7:0] d);
      apb(1'b1, REG_INSTR, {24'h000000, ins});
      apb(1'b1, REG_WDATA, {24'h000000, d});
      mid_clr <= 1'b1;
      apb(1'b1, REG_CTRL, {29'h00000000, sel, rd, 1'b1});
      mid_clr <= 1'b0;
      do apb(1'b0, REG_STATUS, 32'h00000000); while (q[2] !== 1'b1);
   endtask
   initial begin
      rst_n = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00;
      pwdata = 32'h00000000; pin = 1'b1; mid_clr = 1'b0;
      // watchdog: a hang counts as a mismatch and still reaches the verdict
      fork
         begin
            repeat (40000) @(posedge clk);
            fail_count++;
            tally_and_finish();
         end
      join_none
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      repeat (4) @(posedge clk);
      `CHK(wiper, 8'h80)
      `CHK(tap, 256'h1 << 128)
      cmd(1'b0, 1'b1, 8'h9F, 8'h3C);
      `CHK(q[2:0], 3'h4)
      `CHK({a_open, to_b, wiper}, {2'h0, 8'h3C})
      `CHK(tap, 256'h1 << 8'h3C)
      cmd(1'b1, 1'b1, 8'h00, 8'h00);
      apb(1'b0, REG_RDATA, 32'h00000000);
      `CHK(q[7:0], 8'h3C)
      cmd(1'b0, 1'b1, 8'h20, 8'h55);
      `CHK({a_open, to_b, wiper}, {2'h3, 8'h55})
      `CHK(tap, 256'h1)
      cmd(1'b0, 1'b1, 8'h00, 8'h55);
      `CHK({a_open, to_b, tap[8'h55]}, 3'h1)
      cmd(1'b0, 1'b1, 8'h40, 8'h11);
      `CHK({saw_mid, wiper}, {1'b1, 8'h11})
      cmd(1'b0, 1'b0, 8'h00, 8'h22);
      `CHK({q[2:0], wiper}, {3'h6, 8'h11})
      pin <= 1'b0;
      repeat (4) @(posedge clk);
      cmd(1'b0, 1'b0, 8'h00, 8'h22);
      `CHK(wiper, 8'h22)
      apb(1'b0, 8'h20, 32'h00000000);
      `CHK({err, q}, {1'b1, 32'h00000000})
      tally_and_finish();
   end
endmodule
